// File: ats_pkg.sv
// Package for the conversion trigger select block: register map, field
// positions, reset values and the trigger select codes.
// Assumes a 32-bit APB slave port with byte addresses on paddr.
package ats_pkg;

  // Address width of the register port.
  localparam int ATS_ADDR_W = 12;

  // Register byte offsets.
  localparam logic [11:0] ATS_OFF_TRIG_CTRL   = 12'h000;
  localparam logic [11:0] ATS_OFF_RESULT_HIGH = 12'h004;
  localparam logic [11:0] ATS_OFF_CONV_CTRL   = 12'h008;
  localparam logic [11:0] ATS_OFF_STATUS      = 12'h00C;

  // Trigger control field: select code in bits 7 to 4, bits 3 to 0 unused.
  localparam int ATS_SEL_LSB = 4;
  localparam int ATS_SEL_MSB = 7;
  localparam int ATS_SEL_W   = 4;
  localparam int ATS_REG_W   = 8;

  // Conversion control bits.
  localparam int ATS_CC_EN_BIT    = 0;
  localparam int ATS_CC_FMT_BIT   = 1;
  localparam int ATS_CC_START_BIT = 2;

  // Status bits.
  localparam int ATS_ST_BUSY_BIT = 0;
  localparam int ATS_ST_MISS_BIT = 1;

  // Reset values.
  localparam logic [7:0] ATS_TRIG_CTRL_RST   = 8'h00;
  localparam logic [7:0] ATS_RESULT_HIGH_RST = 8'h00;
  localparam logic [7:0] ATS_CONV_CTRL_RST   = 8'h00;

  // Conversion result layout.
  localparam int ATS_RES_W       = 10;
  localparam int ATS_RES_HI_MSB  = 9;
  localparam int ATS_RES_HI_LSB  = 2;
  localparam int ATS_RES_RJ_W    = 2;
  localparam int ATS_NUM_SRC     = 16;

  // Trigger select codes.
  typedef enum logic [3:0] {
    ATS_SEL_NONE   = 4'h0,
    ATS_SEL_CCU1   = 4'h1,
    ATS_SEL_CCU2   = 4'h2,
    ATS_SEL_TMR0   = 4'h3,
    ATS_SEL_TMR1   = 4'h4,
    ATS_SEL_TMR2   = 4'h5,
    ATS_SEL_CMP1   = 4'h6,
    ATS_SEL_CMP2   = 4'h7,
    ATS_SEL_LC1    = 4'h8,
    ATS_SEL_LC2    = 4'h9,
    ATS_SEL_LC3    = 4'hA,
    ATS_SEL_LC4    = 4'hB,
    ATS_SEL_TMR4   = 4'hC,
    ATS_SEL_TMR6   = 4'hD,
    ATS_SEL_RSVD_E = 4'hE,
    ATS_SEL_RSVD_F = 4'hF
  } ats_trig_sel_t;

endpackage : ats_pkg

// File: ats_trigger_select.sv
// Conversion trigger select block: picks one of thirteen on-chip events whose
// rising edge starts a conversion, and holds the upper result byte.
// Assumes all event inputs and the converter handshake are synchronous to
// pclk, and that software reaches the registers over APB with 32-bit data.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps

module ats_trigger_select
  import ats_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ATS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  capture_compare_unit1,
  input  wire logic                  capture_compare_unit2,
  input  wire logic                  timer0_overflow,
  input  wire logic                  timer1_overflow,
  input  wire logic                  timer2_period_match,
  input  wire logic                  comparator1_synced_output,
  input  wire logic                  comparator2_synced_output,
  input  wire logic                  logic_cell1_output,
  input  wire logic                  logic_cell2_output,
  input  wire logic                  logic_cell3_output,
  input  wire logic                  logic_cell4_output,
  input  wire logic                  timer4_period_match,
  input  wire logic                  timer6_period_match,
  input  wire logic                  conv_busy,
  input  wire logic                  conv_done,
  input  wire logic [ATS_RES_W-1:0]  conversion_result,
  output logic                       conv_start,
  output logic                       timer0_flag_set,
  output logic                       timer1_flag_set,
  output logic                       converter_enable,
  output logic                       result_format_select
);

  // Registers and their next values.
  logic [ATS_SEL_W-1:0]   trig_sel_ff;
  logic [ATS_REG_W-1:0]   result_high_ff;
  logic                   conv_en_ff;
  logic                   fmt_ff;
  logic                   missed_ff;
  logic                   nxt_missed;
  logic [ATS_NUM_SRC-1:0] src_prev_ff;
  logic                   conv_start_ff;
  logic                   nxt_conv_start;
  logic                   tmr0_set_ff;
  logic                   tmr1_set_ff;
  logic [31:0]            prdata_ff;
  logic [31:0]            nxt_prdata;

  // Combinational helpers.
  logic [ATS_NUM_SRC-1:0] src_vec;
  logic [ATS_NUM_SRC-1:0] src_rise;
  logic                   sel_rise;
  logic                   auto_req;
  logic                   soft_req;
  logic                   start_req;
  logic                   wr_en;
  logic                   setup_rd;
  logic                   addr_hit;
  logic                   lane0_wr;

  // Picks one bit of the source vector by select code.
  function automatic logic ats_pick(input logic [ATS_NUM_SRC-1:0] vec,
                                    input logic [ATS_SEL_W-1:0]   sel);
    logic bit_out;
    bit_out = 1'b0;
    case (sel)
      ATS_SEL_NONE:   bit_out = 1'b0;
      ATS_SEL_RSVD_E: bit_out = 1'b0;
      ATS_SEL_RSVD_F: bit_out = 1'b0;
      default:        bit_out = vec[sel];
    endcase
    return bit_out;
  endfunction : ats_pick

  // Tells whether an address maps onto one of the four registers.
  function automatic logic ats_mapped(input logic [ATS_ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      ATS_OFF_TRIG_CTRL:   hit = 1'b1;
      ATS_OFF_RESULT_HIGH: hit = 1'b1;
      ATS_OFF_CONV_CTRL:   hit = 1'b1;
      ATS_OFF_STATUS:      hit = 1'b1;
      default:             hit = 1'b0;
    endcase
    return hit;
  endfunction : ats_mapped

  // Gathers the event sources into one vector indexed by select code.
  always_comb begin
    src_vec                 = '0;
    src_vec[ATS_SEL_CCU1]   = capture_compare_unit1;
    src_vec[ATS_SEL_CCU2]   = capture_compare_unit2;
    src_vec[ATS_SEL_TMR0]   = timer0_overflow;
    src_vec[ATS_SEL_TMR1]   = timer1_overflow;
    src_vec[ATS_SEL_TMR2]   = timer2_period_match;
    src_vec[ATS_SEL_CMP1]   = comparator1_synced_output;
    src_vec[ATS_SEL_CMP2]   = comparator2_synced_output;
    src_vec[ATS_SEL_LC1]    = logic_cell1_output;
    src_vec[ATS_SEL_LC2]    = logic_cell2_output;
    src_vec[ATS_SEL_LC3]    = logic_cell3_output;
    src_vec[ATS_SEL_LC4]    = logic_cell4_output;
    src_vec[ATS_SEL_TMR4]   = timer4_period_match;
    src_vec[ATS_SEL_TMR6]   = timer6_period_match;
  end

  // One edge detector per source, so a change of select never fakes an edge.
  genvar gi;
  generate
    for (gi = 0; gi < ATS_NUM_SRC; gi++) begin : g_edge
      // Holds the previous level of this source.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          src_prev_ff[gi] <= 1'b0;
        end else begin
          src_prev_ff[gi] <= src_vec[gi];
        end
      end
      // A rise is high now and low one cycle earlier.
      assign src_rise[gi] = src_vec[gi] & ~src_prev_ff[gi];
    end
  endgenerate

  // Selected edge and the start decision.
  assign sel_rise  = ats_pick(src_rise, trig_sel_ff);
  assign auto_req  = sel_rise & conv_en_ff & ~conv_busy;
  assign soft_req  = wr_en & (paddr == ATS_OFF_CONV_CTRL) & lane0_wr
                     & pwdata[ATS_CC_START_BIT] & conv_en_ff & ~conv_busy;
  assign start_req = auto_req | soft_req;

  // Start pulse goes out one cycle after the edge or the write.
  always_comb begin
    nxt_conv_start = start_req;
  end

  // Registered start pulse to the conversion engine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= nxt_conv_start;
    end
  end

  // Timer overflow as trigger also raises the timer's interrupt flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr0_set_ff <= 1'b0;
      tmr1_set_ff <= 1'b0;
    end else begin
      tmr0_set_ff <= sel_rise & (trig_sel_ff == ATS_SEL_TMR0);
      tmr1_set_ff <= sel_rise & (trig_sel_ff == ATS_SEL_TMR1);
    end
  end

  // An edge that arrives while busy or disabled is dropped and recorded.
  // A new miss in the clearing cycle wins over the clear.
  always_comb begin
    nxt_missed = missed_ff;
    if (wr_en && (paddr == ATS_OFF_STATUS) && lane0_wr
        && pwdata[ATS_ST_MISS_BIT]) begin
      nxt_missed = 1'b0;
    end
    if (sel_rise && !auto_req) begin
      nxt_missed = 1'b1;
    end
  end

  // Sticky missed-trigger flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missed_ff <= 1'b0;
    end else begin
      missed_ff <= nxt_missed;
    end
  end

  // APB decode: write at the access edge, read data captured at setup.
  assign addr_hit = ats_mapped(paddr);
  assign wr_en    = psel & penable & pwrite & addr_hit;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign lane0_wr = pstrb[0];
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;

  // Trigger select register; only bits 7..4 are stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_ff <= ATS_TRIG_CTRL_RST[ATS_SEL_MSB:ATS_SEL_LSB];
    end else if (wr_en && (paddr == ATS_OFF_TRIG_CTRL) && lane0_wr) begin
      trig_sel_ff <= pwdata[ATS_SEL_MSB:ATS_SEL_LSB];
    end
  end

  // Converter enable and result format bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_en_ff <= ATS_CONV_CTRL_RST[ATS_CC_EN_BIT];
      fmt_ff     <= ATS_CONV_CTRL_RST[ATS_CC_FMT_BIT];
    end else if (wr_en && (paddr == ATS_OFF_CONV_CTRL) && lane0_wr) begin
      conv_en_ff <= pwdata[ATS_CC_EN_BIT];
      fmt_ff     <= pwdata[ATS_CC_FMT_BIT];
    end
  end

  // Result high byte: the finished conversion wins over a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_high_ff <= ATS_RESULT_HIGH_RST;
    end else if (conv_done) begin
      if (!fmt_ff) begin
        result_high_ff <= conversion_result[ATS_RES_HI_MSB:ATS_RES_HI_LSB];
      end else begin
        result_high_ff <= {{(ATS_REG_W-ATS_RES_RJ_W){1'b0}},
                           conversion_result[ATS_RES_W-1:ATS_RES_HI_LSB+
                                             (ATS_REG_W-ATS_RES_RJ_W)]};
      end
    end else if (wr_en && (paddr == ATS_OFF_RESULT_HIGH) && lane0_wr) begin
      result_high_ff <= pwdata[ATS_REG_W-1:0];
    end
  end

  // Read data mux; unused bits above the register width read as zero.
  always_comb begin
    nxt_prdata = '0;
    case (paddr)
      ATS_OFF_TRIG_CTRL: begin
        nxt_prdata[ATS_SEL_MSB:ATS_SEL_LSB] = trig_sel_ff;
      end
      ATS_OFF_RESULT_HIGH: begin
        nxt_prdata[ATS_REG_W-1:0] = result_high_ff;
      end
      ATS_OFF_CONV_CTRL: begin
        nxt_prdata[ATS_CC_EN_BIT]  = conv_en_ff;
        nxt_prdata[ATS_CC_FMT_BIT] = fmt_ff;
      end
      ATS_OFF_STATUS: begin
        nxt_prdata[ATS_ST_BUSY_BIT] = conv_busy;
        nxt_prdata[ATS_ST_MISS_BIT] = missed_ff;
      end
      default: begin
        nxt_prdata = '0;
      end
    endcase
  end

  // Read data register, loaded in the setup cycle of a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (setup_rd) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // Outputs.
  assign prdata               = prdata_ff;
  assign conv_start           = conv_start_ff;
  assign timer0_flag_set      = tmr0_set_ff;
  assign timer1_flag_set      = tmr1_set_ff;
  assign converter_enable     = conv_en_ff;
  assign result_format_select = fmt_ff;

endmodule : ats_trigger_select

// File: ats_event_model.sv
// Model of the on-chip event sources seen by the trigger select block.
// Assumes the bench raises fire_mask for one cycle for each pulse.
`timescale 1ns/10ps

module ats_event_model
  import ats_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [12:0] fire_mask,
  output logic      [12:0] evt_ff
);
  // Each event is high for one cycle and low after, so every pulse is a fresh edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= 13'h0000;
    end else begin
      evt_ff <= fire_mask;
    end
  end
endmodule : ats_event_model

// File: ats_trigger_select_sva.sv
// Checker for the trigger select block, bound to its top module.
// Assumes a single pclk domain and the register map of ats_pkg.
`timescale 1ns/10ps

module ats_trigger_select_chk
  import ats_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ATS_ADDR_W-1:0] paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 capture_compare_unit1,
  input wire logic                 capture_compare_unit2,
  input wire logic                 timer0_overflow,
  input wire logic                 timer1_overflow,
  input wire logic                 timer2_period_match,
  input wire logic                 comparator1_synced_output,
  input wire logic                 comparator2_synced_output,
  input wire logic                 logic_cell1_output,
  input wire logic                 logic_cell2_output,
  input wire logic                 logic_cell3_output,
  input wire logic                 logic_cell4_output,
  input wire logic                 timer4_period_match,
  input wire logic                 timer6_period_match,
  input wire logic                 conv_busy,
  input wire logic                 conv_start,
  input wire logic                 timer0_flag_set,
  input wire logic                 timer1_flag_set,
  input wire logic                 converter_enable,
  input wire logic                 result_format_select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [12:0] ev, prev_ff;
  logic [3:0]  sel_ff;
  logic        acc, hit, wr8, sw_wr;
  // Events in select-code order: code N sits at bit N-1.
  assign ev = {timer6_period_match, timer4_period_match, logic_cell4_output,
    logic_cell3_output, logic_cell2_output, logic_cell1_output, comparator2_synced_output,
    comparator1_synced_output, timer2_period_match, timer1_overflow, timer0_overflow,
    capture_compare_unit2, capture_compare_unit1};
  assign acc = psel && penable;
  assign hit = sel_ff != 4'h0 && sel_ff <= 4'hD && ev[sel_ff-4'h1] && !prev_ff[sel_ff-4'h1];
  assign wr8 = acc && pwrite && pstrb[0] && paddr == 12'h008;
  assign sw_wr = wr8 && pwdata[2];
  // Mirrors the select field and the previous event levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 13'h0000;
      sel_ff  <= 4'h0;
    end else begin
      prev_ff <= ev;
      if (acc && pwrite && pstrb[0] && paddr == 12'h000) sel_ff <= pwdata[7:4];
    end
  end
  sequence s_edge_ok;
    hit && converter_enable && !conv_busy;
  endsequence
  property p_start; s_edge_ok |=> conv_start; endproperty
  property p_quiet; !hit && !sw_wr |=> !conv_start; endproperty
  property p_blocked; hit && (!converter_enable || conv_busy) && !sw_wr |=> !conv_start; endproperty
  property p_t0; hit && sel_ff == 4'h3 |=> timer0_flag_set; endproperty
  property p_t1; !(hit && sel_ff == 4'h4) |=> !timer1_flag_set; endproperty
  property p_ctrl; acc && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, sel_ff, 4'h0}; endproperty
  property p_en; wr8 |=> converter_enable == $past(pwdata[0]); endproperty
  property p_fmt; wr8 |=> result_format_select == $past(pwdata[1]); endproperty
  a_start: assert property (p_start) else $error("no start after trigger edge");
  a_quiet: assert property (p_quiet) else $error("start without a cause");
  a_blocked: assert property (p_blocked) else $error("start while off or busy");
  a_t0: assert property (p_t0) else $error("timer0 flag missing");
  a_t1: assert property (p_t1) else $error("stray timer1 flag");
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  a_en: assert property (p_en) else $error("enable not stored");
  a_fmt: assert property (p_fmt) else $error("format not stored");
endmodule : ats_trigger_select_chk

bind ats_trigger_select ats_trigger_select_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .capture_compare_unit1(capture_compare_unit1),
  .capture_compare_unit2(capture_compare_unit2), .timer0_overflow(timer0_overflow),
  .timer1_overflow(timer1_overflow), .timer2_period_match(timer2_period_match),
  .comparator1_synced_output(comparator1_synced_output),
  .comparator2_synced_output(comparator2_synced_output),
  .logic_cell1_output(logic_cell1_output), .logic_cell2_output(logic_cell2_output),
  .logic_cell3_output(logic_cell3_output), .logic_cell4_output(logic_cell4_output),
  .timer4_period_match(timer4_period_match), .timer6_period_match(timer6_period_match),
  .conv_busy(conv_busy), .conv_start(conv_start), .timer0_flag_set(timer0_flag_set),
  .timer1_flag_set(timer1_flag_set), .converter_enable(converter_enable),
  .result_format_select(result_format_select));

// File: test_adc_auto_trigger_select.sv
// Self-checking bench for the trigger select block.
// Assumes the event model drives the sources; the bench is bus master and converter.
`timescale 1ns/10ps

module test_adc_auto_trigger_select
  import ats_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr, err, conv_busy = 1'b0, conv_done = 1'b0, conv_start;
  logic        t0f, t1f, cen, fmt, s, a, b;
  logic [9:0]  cres = 10'h000;
  logic [12:0] mask = 13'h0000, evt, own;
  // Rows hold {select code, start, timer0 flag, timer1 flag}.
  // Reserved codes 14 and 15 are never written, so the last rows reuse code 0.
  logic [6:0]  rows [16] = '{7'h00, 7'h0C, 7'h14, 7'h1E, 7'h25, 7'h2C, 7'h34, 7'h3C,
                             7'h44, 7'h4C, 7'h54, 7'h5C, 7'h64, 7'h6C, 7'h00, 7'h00};
  int          bad_count = 0, n_tests = 0, cyc = 0;

  always #2.5 pclk = ~pclk;

  ats_event_model ev_u (.pclk(pclk), .presetn(presetn), .fire_mask(mask), .evt_ff(evt));
  ats_trigger_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_compare_unit1(evt[0]),
    .capture_compare_unit2(evt[1]), .timer0_overflow(evt[2]), .timer1_overflow(evt[3]),
    .timer2_period_match(evt[4]), .comparator1_synced_output(evt[5]),
    .comparator2_synced_output(evt[6]), .logic_cell1_output(evt[7]),
    .logic_cell2_output(evt[8]), .logic_cell3_output(evt[9]), .logic_cell4_output(evt[10]),
    .timer4_period_match(evt[11]), .timer6_period_match(evt[12]), .conv_busy(conv_busy),
    .conv_done(conv_done), .conversion_result(cres), .conv_start(conv_start),
    .timer0_flag_set(t0f), .timer1_flag_set(t1f), .converter_enable(cen),
    .result_format_select(fmt));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Pulses the masked sources and gathers the outputs over a short window.
  task automatic fire(input logic [12:0] m);
    mask <= m;
    @(posedge pclk);
    mask <= 13'h0000;
    {s, a, b} = 3'b000;
    repeat (5) begin
      @(posedge pclk);
      s = s | conv_start;
      a = a | t0f;
      b = b | t1f;
    end
  endtask : fire

  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end

  // Reset, the row loop, then the awkward cases.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(d, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(d, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    foreach (rows[i]) begin
      own = rows[i][2] ? 13'h0001 << (rows[i][6:3] - 4'h1) : 13'h1FFF;
      apb(1'b1, 12'h000, {24'h0, rows[i][6:3], 4'hF});
      apb(1'b0, 12'h000, 32'h0);
      chk(d, {24'h0, rows[i][6:3], 4'h0});
      if (rows[i][2]) begin
        fire(~own);
        chk({s, a, b}, 3'b000);
      end
      fire(own);
      chk({s, a, b}, rows[i][2:0]);
    end
    apb(1'b1, 12'h000, 32'h30);
    conv_busy <= 1'b1;
    fire(13'h0004);
    chk({s, a, b}, 3'b010);
    conv_busy <= 1'b0;
    apb(1'b1, 12'h008, 32'h0);
    fire(13'h0004);
    chk({s, a, b}, 3'b010);
    apb(1'b0, 12'h00C, 32'h0);
    chk(d, 32'h2);
    apb(1'b1, 12'h00C, 32'h2);
    apb(1'b0, 12'h00C, 32'h0);
    chk(d, 32'h0);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h008, 32'h5);
    chk({31'h0, conv_start}, 32'h1);
    apb(1'b1, 12'h004, 32'h5A);
    apb(1'b0, 12'h004, 32'h0);
    chk(d, 32'h5A);
    cres <= 10'h2B5;
    conv_done <= 1'b1;
    @(posedge pclk);
    conv_done <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(d, 32'hAD);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk(d, 32'h0);
    chk({30'h0, cen, fmt}, 32'h0);
    close_out();
  end
endmodule : test_adc_auto_trigger_select
